// ==== hdl/dtn_device.sv ====
// framer end: nibble clock generator, payload sampler, fifo and axi4-lite registers
`timescale 1ns/100ps

// small flop fifo, storage indexed by pointers
module dtn_fifo
	import dtn_pkg::*;
#(
	parameter int W     = 4,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic         clock_i,
	input  wire logic         rstn_i,
	input  wire logic         ce_i,
	// fill side
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	// drain side
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0]  mem_q [DEPTH];          // storage
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d; // pointers
	logic [PW:0]   cnt_q, cnt_d;           // fill level
	logic          push, pop;

	// pointer and level update
	always_comb begin
		push  = in_valid_i & (cnt_q != (PW+1)'(DEPTH));
		pop   = out_ready_i & (cnt_q != '0);
		wr_d  = push ? ((wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
		rd_d  = pop ? ((rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
		cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (ce_i) begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
			if (push) begin
				mem_q[wr_q] <= in_data_i;
			end
		end
	end

	// honest flags straight from the level
	assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rd_q];
endmodule

module dtn_device
	import dtn_pkg::*;
(
	// clock, reset, freeze
	input  wire logic          clock_i,
	input  wire logic          rstn_i,
	input  wire logic          ce_i,
	// link pins
	dtn_link_if.device         link,
	// axi4-lite slave
	input  wire logic [15:0]   s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [15:0]   s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// payload stream to the framer core
	output logic [3:0]         payload_o,
	output logic               payload_valid_o,
	input  wire logic          payload_ready_i
);
	// pin synchronisers: stage one feeds stage two only
	logic [3:0] nib_s1_q, nib_s2_q;     // payload nibble
	logic       ref_s1_q, ref_s2_q, ref_s3_q; // frame reference, s3 for edge
	logic       sel_s1_q, sel_s2_q;     // nibble interface select
	logic       txc_s1_q, txc_s2_q;     // local bit clock
	logic       lnc_s1_q, lnc_s2_q;     // recovered line clock
	logic       bitc_prev_q;            // chosen bit clock, one sample late

	// link state
	logic [DTN_PH_W-1:0]  ph_q, ph_d;     // bit cycle inside nibble period
	logic [DTN_IDX_W-1:0] idx_q, idx_d;   // nibble index in frame
	logic [DTN_RUN_W-1:0] run_q, run_d;   // nibble index in payload run
	logic                 nclk_q, nclk_d; // nibble clock pin
	logic                 fend_q, fend_d; // frame end pin
	logic                 rclk_q;         // recovered clock pin
	logic                 ovr_q, ovr_d;   // sticky overrun
	logic [15:0]          frames_q, frames_d;
	logic                 bit_tick, ref_rise, sample, fifo_rdy, ovr_clr, slave, bitc;

	// register state
	logic [7:0]  mode_q, mode_d;
	logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
	logic        awh_q, awh_d, wh_q, wh_d;
	logic [15:0] awa_q, awa_d;
	logic [7:0]  wd_q, wd_d;
	logic        ws_q, ws_d;
	logic [1:0]  br_q, br_d, rr_q, rr_d;
	logic [31:0] rd_q, rd_d;

	// timing source pick: frame-slave uses the local clock, every other setting the recovered clock
	assign slave = (mode_q[DTN_TREF_LSB +: 2] == DTN_TREF_SLAVE);
	assign bitc  = slave ? txc_s2_q : lnc_s2_q;
	assign bit_tick = bitc & ~bitc_prev_q;
	assign ref_rise = slave & ref_s2_q & ~ref_s3_q;
	// latch on the third bit edge after the nibble clock rose
	assign sample   = bit_tick & sel_s2_q & (ph_q == DTN_PH_SAMPLE);

	// synchronisers and pin echo
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{nib_s1_q, nib_s2_q} <= 8'h00;
			{ref_s1_q, ref_s2_q, ref_s3_q} <= 3'h0;
			{sel_s1_q, sel_s2_q, txc_s1_q, txc_s2_q} <= 4'h0;
			{lnc_s1_q, lnc_s2_q, bitc_prev_q, rclk_q} <= 4'h0;
		end else if (ce_i) begin
			nib_s1_q    <= link.tx_payload_nibble;
			nib_s2_q    <= nib_s1_q;
			ref_s1_q    <= link.frame_start_reference;
			ref_s2_q    <= ref_s1_q;
			ref_s3_q    <= ref_s2_q;
			sel_s1_q    <= link.nibble_interface_select;
			sel_s2_q    <= sel_s1_q;
			txc_s1_q    <= link.tx_bit_clock_in;
			txc_s2_q    <= txc_s1_q;
			lnc_s1_q    <= link.line_clock;
			lnc_s2_q    <= lnc_s1_q;
			bitc_prev_q <= bitc;
			rclk_q      <= lnc_s2_q;
		end
	end

	// nibble clock generator and frame counters
	always_comb begin
		ph_d     = ph_q;
		idx_d    = idx_q;
		run_d    = run_q;
		frames_d = frames_q;
		// serial mode is not served here: hold the generator at a period start
		if (!sel_s2_q) begin
			ph_d  = '0;
			idx_d = '0;
			run_d = '0;
		end else if (bit_tick) begin
			// last nibble of each 84-bit run is stretched over the overhead slot
			if (ph_q == ((run_q == DTN_LAST_RUN) ? DTN_PH_LONG : DTN_PH_SHORT)) begin
				ph_d  = '0;
				run_d = (run_q == DTN_LAST_RUN) ? '0 : run_q + 1'b1;
				idx_d = (idx_q == DTN_LAST_NIB) ? '0 : idx_q + 1'b1;
				if (idx_q == DTN_LAST_NIB) begin
					frames_d = frames_q + 16'h0001;
				end
			end else begin
				ph_d = ph_q + 1'b1;
			end
		end
		// reference edge wins: the current nibble becomes the first of a frame
		if (sel_s2_q && ref_rise) begin
			idx_d    = '0;
			run_d    = '0;
			frames_d = frames_q + 16'h0001;
		end
		nclk_d = sel_s2_q & (ph_d < DTN_PH_HIGH);
		fend_d = sel_s2_q & (idx_d == DTN_LAST_NIB);
		// overrun sets even in the cycle software clears it
		ovr_d  = (ovr_q & ~ovr_clr) | (sample & ~fifo_rdy);
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ph_q     <= '0;
			idx_q    <= '0;
			run_q    <= '0;
			nclk_q   <= 1'b0;
			fend_q   <= 1'b0;
			ovr_q    <= 1'b0;
			frames_q <= 16'h0000;
		end else if (ce_i) begin
			ph_q     <= ph_d;
			idx_q    <= idx_d;
			run_q    <= run_d;
			nclk_q   <= nclk_d;
			fend_q   <= fend_d;
			ovr_q    <= ovr_d;
			frames_q <= frames_d;
		end
	end

	// sampled nibbles are payload only; overhead is made inside the framer
	dtn_fifo #(.W(DTN_NIB_W), .DEPTH(DTN_FIFO_DEPTH)) u_fifo (
		.clock_i     (clock_i),
		.rstn_i      (rstn_i),
		.ce_i        (ce_i),
		.in_data_i   (nib_s2_q),
		.in_valid_i  (sample),
		.in_ready_o  (fifo_rdy),
		.out_data_o  (payload_o),
		.out_valid_o (payload_valid_o),
		.out_ready_i (payload_ready_i)
	);

	// link pins straight from flops; overhead indicator has no meaning here
	assign link.tx_nibble_clock_out = nclk_q;
	assign link.frame_end_pulse     = fend_q;
	assign link.overhead_indicator  = 1'b0 & ovr_q;
	assign link.recovered_clock_out = rclk_q;

	// axi4-lite: address and data taken in either order, one answer each
	always_comb begin
		mode_d  = mode_q;
		awh_d   = awh_q;
		awa_d   = awa_q;
		wh_d    = wh_q;
		wd_d    = wd_q;
		ws_d    = ws_q;
		bv_d    = bv_q & ~s_axi_bready;
		br_d    = br_q;
		rv_d    = rv_q & ~s_axi_rready;
		rd_d    = rd_q;
		rr_d    = rr_q;
		ovr_clr = 1'b0;
		if (s_axi_awvalid && awr_q) begin
			awh_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_q) begin
			wh_d = 1'b1;
			wd_d = s_axi_wdata[7:0];
			ws_d = s_axi_wstrb[0];
		end
		// write completes once both halves are held and no answer is pending
		if (awh_q && wh_q && !bv_q) begin
			awh_d = 1'b0;
			wh_d  = 1'b0;
			bv_d  = 1'b1;
			br_d  = DTN_RESP_OKAY;
			if (awa_q == DTN_ADDR_MODE) begin
				if (ws_q) begin
					mode_d = wd_q;
				end
			end else if (awa_q == DTN_ADDR_STATUS) begin
				ovr_clr = ws_q & wd_q[DTN_ST_OVR];
			end else if (awa_q == DTN_ADDR_FRAMES) begin
				br_d = DTN_RESP_OKAY; // read-only, write ignored
			end else begin
				br_d = DTN_RESP_SLVERR;
			end
		end
		// read decode
		if (s_axi_arvalid && arr_q) begin
			rv_d = 1'b1;
			rr_d = DTN_RESP_OKAY;
			if (s_axi_araddr == DTN_ADDR_MODE) begin
				rd_d = {24'h000000, mode_q};
			end else if (s_axi_araddr == DTN_ADDR_STATUS) begin
				rd_d = 32'h00000000;
				rd_d[DTN_ST_OVR]    = ovr_q;
				rd_d[DTN_ST_NIBSEL] = sel_s2_q;
			end else if (s_axi_araddr == DTN_ADDR_FRAMES) begin
				rd_d = {16'h0000, frames_q};
			end else begin
				rd_d = 32'h00000000;
				rr_d = DTN_RESP_SLVERR;
			end
		end
		awr_d = ~awh_d & ~bv_d;
		wr_d  = ~wh_d & ~bv_d;
		arr_d = ~rv_d;
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_q <= DTN_MODE_RESET;
			{awr_q, wr_q, arr_q, bv_q, rv_q, awh_q, wh_q, ws_q} <= 8'h00;
			awa_q  <= 16'h0000;
			wd_q   <= 8'h00;
			br_q   <= 2'h0;
			rr_q   <= 2'h0;
			rd_q   <= 32'h00000000;
		end else if (ce_i) begin
			mode_q <= mode_d;
			awr_q  <= awr_d;
			wr_q   <= wr_d;
			arr_q  <= arr_d;
			bv_q   <= bv_d;
			rv_q   <= rv_d;
			awh_q  <= awh_d;
			wh_q   <= wh_d;
			ws_q   <= ws_d;
			awa_q  <= awa_d;
			wd_q   <= wd_d;
			br_q   <= br_d;
			rr_q   <= rr_d;
			rd_q   <= rd_d;
		end
	end

	assign s_axi_awready = awr_q;
	assign s_axi_wready  = wr_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;
endmodule

// ==== hdl/dtn_host.sv ====
// system-side end: feeds payload nibbles on the device nibble clock
`timescale 1ns/100ps
module dtn_host
	import dtn_pkg::*;
(
	// clock, reset, freeze
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       ce_i,
	// link pins
	dtn_link_if.host        link,
	// user side
	input  wire logic       slave_mode_i,   // high: device runs frame-slave
	input  wire logic [3:0] src_data_i,     // payload nibble to send
	input  wire logic       src_valid_i,
	output logic            src_ready_o,    // one-cycle pulse, nibble taken
	output logic            frame_start_o   // one-cycle pulse, first nibble driven
);
	// synchronisers
	logic nck_s1_q, nck_s2_q, nck_s3_q; // nibble clock, s3 for edge
	logic fe_s1_q, fe_s2_q, fe_s3_q;    // frame end, s3 for edge
	// drive state
	logic [3:0] dat_q, dat_d;           // nibble on the pins
	logic       ref_q, ref_d;           // frame reference pin
	logic       pend_q, pend_d;         // next nibble opens a frame
	logic       rdy_q, rdy_d;
	logic       fs_q, fs_d;
	logic       sel_q;                  // nibble interface select pin
	logic       nck_rise, fe_rise;

	assign nck_rise = nck_s2_q & ~nck_s3_q;
	assign fe_rise  = fe_s2_q & ~fe_s3_q;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{nck_s1_q, nck_s2_q, nck_s3_q} <= 3'h0;
			{fe_s1_q, fe_s2_q, fe_s3_q}    <= 3'h0;
		end else if (ce_i) begin
			nck_s1_q <= link.tx_nibble_clock_out;
			nck_s2_q <= nck_s1_q;
			nck_s3_q <= nck_s2_q;
			fe_s1_q  <= link.frame_end_pulse;
			fe_s2_q  <= fe_s1_q;
			fe_s3_q  <= fe_s2_q;
		end
	end

	// drive a fresh nibble on each nibble clock rise
	always_comb begin
		dat_d  = dat_q;
		ref_d  = ref_q;
		rdy_d  = 1'b0;
		fs_d   = 1'b0;
		// frame end seen: the next nibble opens a frame; set wins over clear
		pend_d = (pend_q & ~nck_rise) | fe_rise;
		if (nck_rise) begin
			dat_d = src_valid_i ? src_data_i : 4'h0;
			rdy_d = src_valid_i;
			fs_d  = pend_q;
			// reference lasts one nibble period, moved only on nibble edges
			ref_d = pend_q & slave_mode_i;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dat_q  <= 4'h0;
			ref_q  <= 1'b0;
			pend_q <= 1'b1; // first nibble after reset opens a frame
			rdy_q  <= 1'b0;
			fs_q   <= 1'b0;
			sel_q  <= 1'b1;
		end else if (ce_i) begin
			dat_q  <= dat_d;
			ref_q  <= ref_d;
			pend_q <= pend_d;
			rdy_q  <= rdy_d;
			fs_q   <= fs_d;
			sel_q  <= 1'b1;
		end
	end

	assign link.tx_payload_nibble       = dat_q;
	assign link.frame_start_reference   = ref_q;
	assign link.nibble_interface_select = sel_q;
	assign src_ready_o   = rdy_q;
	assign frame_start_o = fs_q;
endmodule

// ==== include/dtn_link_if.sv ====
// pin-level link between the framer and the system-side equipment
`timescale 1ns/100ps
interface dtn_link_if;
	logic [3:0] tx_payload_nibble;       // payload nibble, host to device
	logic       tx_nibble_clock_out;     // gapped nibble clock, device to host
	logic       frame_end_pulse;         // high during last nibble of frame
	logic       frame_start_reference;   // frame-slave start pulse, host to device
	logic       overhead_indicator;      // unused in ds3 nibble mode, held low
	logic       nibble_interface_select; // high selects nibble-parallel
	logic       tx_bit_clock_in;         // local bit clock, made by the bench
	logic       line_clock;              // recovered line clock, made by the bench
	logic       recovered_clock_out;     // recovered clock echoed by the device

	modport device (
		input  tx_payload_nibble, frame_start_reference, nibble_interface_select,
		input  tx_bit_clock_in, line_clock,
		output tx_nibble_clock_out, frame_end_pulse, overhead_indicator,
		output recovered_clock_out
	);
	modport host (
		output tx_payload_nibble, frame_start_reference, nibble_interface_select,
		input  tx_nibble_clock_out, frame_end_pulse, overhead_indicator
	);
endinterface

// ==== include/dtn_pkg.sv ====
// shared constants for the ds3 nibble payload link, both ends
package dtn_pkg;
	// frame structure
	localparam int DTN_FRAME_BITS  = 4760;   // bits in one ds3 frame
	localparam int DTN_OH_BITS     = 56;     // overhead bits per frame
	localparam int DTN_RUN_BITS    = 84;     // payload bits between two overhead bits
	localparam int DTN_NIB_W       = 4;      // nibble width
	localparam int DTN_FRAME_NIBS  = (DTN_FRAME_BITS - DTN_OH_BITS) / DTN_NIB_W; // 1176
	localparam int DTN_RUN_NIBS    = DTN_RUN_BITS / DTN_NIB_W;                   // 21
	// nibble clock shaping, in bit-clock cycles
	localparam int DTN_SHORT_PER   = 4;      // plain nibble period
	localparam int DTN_LONG_PER    = 5;      // stretched period holding an overhead slot
	localparam int DTN_HIGH_CYC    = 2;      // nibble clock high time
	localparam int DTN_SAMPLE_EDGE = 3;      // bit edge after nibble rise that latches data
	// counter widths and typed limits
	localparam int DTN_IDX_W = 11;
	localparam int DTN_RUN_W = 5;
	localparam int DTN_PH_W  = 3;
	localparam logic [DTN_IDX_W-1:0] DTN_LAST_NIB   = DTN_IDX_W'(DTN_FRAME_NIBS - 1);
	localparam logic [DTN_RUN_W-1:0] DTN_LAST_RUN   = DTN_RUN_W'(DTN_RUN_NIBS - 1);
	localparam logic [DTN_PH_W-1:0]  DTN_PH_SHORT   = DTN_PH_W'(DTN_SHORT_PER - 1);
	localparam logic [DTN_PH_W-1:0]  DTN_PH_LONG    = DTN_PH_W'(DTN_LONG_PER - 1);
	localparam logic [DTN_PH_W-1:0]  DTN_PH_HIGH    = DTN_PH_W'(DTN_HIGH_CYC);
	localparam logic [DTN_PH_W-1:0]  DTN_PH_SAMPLE  = DTN_PH_W'(DTN_SAMPLE_EDGE - 1);
	// register map (byte addresses) and fields
	localparam int DTN_AW = 16;
	localparam logic [DTN_AW-1:0] DTN_ADDR_MODE   = 16'h1100; // framer_mode_control
	localparam logic [DTN_AW-1:0] DTN_ADDR_STATUS = 16'h1104; // link status
	localparam logic [DTN_AW-1:0] DTN_ADDR_FRAMES = 16'h1108; // frame start counter
	localparam logic [7:0]  DTN_MODE_RESET  = 8'h00;
	localparam int          DTN_TREF_LSB    = 0;
	localparam logic [1:0]  DTN_TREF_LOOP   = 2'h0;
	localparam logic [1:0]  DTN_TREF_SLAVE  = 2'h1;
	localparam int          DTN_ST_OVR      = 0;      // sticky fifo overrun, write one clears
	localparam int          DTN_ST_NIBSEL   = 1;      // nibble interface select level
	localparam logic [1:0]  DTN_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  DTN_RESP_SLVERR = 2'h2;
	localparam int          DTN_FIFO_DEPTH  = 4;
endpackage

// ==== tb/ds3_tx_nibble_payload_input_tb_top.sv ====
// self-checking bench: framer and system-side ends joined over the nibble link
`timescale 1ns/100ps
module ds3_tx_nibble_payload_input_tb_top
	import dtn_pkg::*;
;
	logic        clock_i, rstn_i, bclk, lc_en;  // clocks, reset, line clock gate
	logic [15:0] awaddr, araddr;                // register bus addresses
	logic [31:0] wdata, rdata, rd, r0;          // bus data, last read, saved read
	logic [3:0]  wstrb, pl_data;                // strobes, framer output
	logic [3:0]  src_data = 4'h0;               // host source, advanced by the scoreboard only
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;            // responses, last one seen
	logic        pl_ready, pl_valid, slave_mode, src_ready, cmp_en, fstart;
	logic [3:0]  exp_q[$];                      // nibbles handed to the host, oldest first
	int          n_errors, n_tests, i, k;
	int          n_rise = 0;                    // nibble clock rises, counted by its own process
	dtn_link_if lnk ();

	// 200 MHz system clock; bit clock free running, phase unrelated to it
	always #2.5 clock_i = ~clock_i;
	initial begin
		bclk = 1'b0;
		#1.3;
		forever #62.5 bclk = ~bclk;
	end
	assign lnk.tx_bit_clock_in = bclk;
	assign lnk.line_clock      = bclk & lc_en;  // gate only moved while bclk is low
	always @(posedge lnk.tx_nibble_clock_out) n_rise++;

	dtn_device u_dtn_device (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1), .link(lnk.device),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.payload_o(pl_data), .payload_valid_o(pl_valid), .payload_ready_i(pl_ready));
	dtn_host u_dtn_host (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1), .link(lnk.host),
		.slave_mode_i(slave_mode), .src_data_i(src_data), .src_valid_i(1'b1),
		.src_ready_o(src_ready), .frame_start_o(fstart));
	dtn_checker u_dtn_checker (.clock_i(clock_i), .rstn_i(rstn_i),
		.tx_payload_nibble(lnk.tx_payload_nibble), .tx_nibble_clock_out(lnk.tx_nibble_clock_out),
		.frame_end_pulse(lnk.frame_end_pulse), .frame_start_reference(lnk.frame_start_reference),
		.overhead_indicator(lnk.overhead_indicator), .line_clock(lnk.line_clock),
		.nibble_interface_select(lnk.nibble_interface_select),
		.recovered_clock_out(lnk.recovered_clock_out));

	// verdict and end of run
	task automatic test_done();
		$display("compares %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// a wait that ran out
	task automatic hang();
		n_errors++;
		test_done();
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// one write; address and data offered together, each dropped once taken
	task automatic axw(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		int j;
		@(posedge clock_i);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (j = 0; j < 100; j++) begin
			@(posedge clock_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (j == 100) hang();
	endtask

	// one read; data and response land in rd and resp
	task automatic axr(input logic [15:0] a);
		int j;
		@(posedge clock_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (j = 0; j < 100; j++) begin
			@(posedge clock_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rd = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (j == 100) hang();
	endtask

	// scoreboard: each nibble the host hands out must leave the framer, in order
	always @(posedge clock_i) begin
		if (src_ready) begin
			exp_q.push_back(src_data);
			src_data <= src_data + 4'h1;
		end
		// frame start pulse carries the reference only in frame-slave mode
		if (fstart)
			check(32'(lnk.frame_start_reference), 32'(slave_mode));
		if (cmp_en && pl_valid && pl_ready) begin
			if (exp_q.size() == 0)
				check(32'h1, 32'h0);
			else
				check(32'(pl_data), 32'(exp_q.pop_front()));
		end
	end

	initial begin
		clock_i = 1'b0; rstn_i = 1'b0; lc_en = 1'b1; awaddr = '0; araddr = '0;
		wdata = '0; wstrb = '0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
		arvalid = 1'b0; rready = 1'b0; pl_ready = 1'b1; slave_mode = 1'b0;
		cmp_en = 1'b1; n_errors = 0; n_tests = 0;
		repeat (6) @(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (20) @(posedge clock_i);
		// loop timing out of reset, stream running on the line clock
		axr(DTN_ADDR_MODE);
		check(rd, 32'(DTN_MODE_RESET));
		repeat (3000) @(posedge clock_i);
		// line clock stopped: loop timing must freeze the nibble clock
		@(negedge bclk) lc_en = 1'b0;
		k = n_rise;
		repeat (500) @(posedge clock_i);
		check(32'(n_rise - k), 32'h0);
		@(negedge bclk) lc_en = 1'b1;
		// unmapped place answers with an error both ways
		axw(16'h1200, 32'h1, 4'h1);
		check(32'(resp), 32'(DTN_RESP_SLVERR));
		axr(16'h1200);
		check({rd[29:0], resp}, 32'(DTN_RESP_SLVERR));
		// upper bits ignored, masked lane leaves the register alone
		axw(DTN_ADDR_MODE, 32'h0000_0FA5, 4'h1);
		axw(DTN_ADDR_MODE, 32'h0000_0000, 4'h0);
		axr(DTN_ADDR_MODE);
		check(rd, 32'h0000_00A5);
		axw(DTN_ADDR_MODE, 32'(DTN_TREF_SLAVE), 4'h1);
		slave_mode <= 1'b1;
		axr(DTN_ADDR_MODE);
		check(rd, 32'(DTN_TREF_SLAVE));
		// line clock stopped: local timing must keep the nibble clock going
		@(negedge bclk) lc_en = 1'b0;
		k = n_rise;
		repeat (500) @(posedge clock_i);
		check(32'(n_rise - k >= 4), 32'h1);
		@(negedge bclk) lc_en = 1'b1;
		// run to the end of the first frame; its last nibble is a stretched one
		axr(DTN_ADDR_FRAMES);
		r0 = rd;
		for (i = 0; i < 130000 && lnk.frame_end_pulse !== 1'b1; i++) @(negedge clock_i);
		if (i == 130000) hang();
		for (k = 0; k < 200 && lnk.frame_end_pulse === 1'b1; k++) @(negedge clock_i);
		check(32'(k >= 123 && k <= 127), 32'h1);
		for (i = 0; i < 400 && lnk.frame_start_reference !== 1'b1; i++) @(negedge clock_i);
		check(32'(i < 400), 32'h1);
		repeat (300) @(posedge clock_i);
		axr(DTN_ADDR_FRAMES);
		// the natural wrap and the reference restart each count one frame start
		check(rd, r0 + 32'h2);
		// stall the drain past the fifo depth so a sampled nibble has nowhere to go
		cmp_en   <= 1'b0;
		pl_ready <= 1'b0;
		repeat (800) @(posedge clock_i);
		check(32'(pl_valid), 32'h1);
		axr(DTN_ADDR_STATUS);
		check(rd, 32'h3);
		pl_ready <= 1'b1;
		for (i = 0; i < 50 && pl_valid; i++) @(negedge clock_i);
		check(32'(pl_valid), 32'h0);
		axw(DTN_ADDR_STATUS, 32'h1, 4'h1);
		axr(DTN_ADDR_STATUS);
		check(rd, 32'h2);
		test_done();
	end
endmodule

// ==== tb/dtn_checker.sv ====
// concurrent checks on the nibble link between the framer and the system side
`timescale 1ns/100ps
module dtn_checker (
	// clock and reset
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	// link signals
	input  wire logic [3:0] tx_payload_nibble,
	input  wire logic       tx_nibble_clock_out,
	input  wire logic       frame_end_pulse,
	input  wire logic       frame_start_reference,
	input  wire logic       overhead_indicator,
	input  wire logic       nibble_interface_select,
	input  wire logic       line_clock,
	input  wire logic       recovered_clock_out
);
	logic        nc_q, fe_q;        // last sampled nibble clock and frame end
	logic        lsync_q, lsync_d;  // set once a stretched period has been seen
	logic [7:0]  per_q, per_d;      // clk since nibble clock rise, ff means none yet or a period too long to count
	logic [4:0]  sh_q, sh_d;        // plain periods since the last stretched one
	logic [10:0] cnt_q, cnt_d;      // nibble clock rises in the current frame
	logic [2:0]  up_q, up_d;        // clk since reset, saturating
	logic        seen_q, seen_d;    // first nibble clock rise seen
	logic        rise, long_p;      // nibble clock rise, ending period was stretched

	// a stretched period is five bit cycles, about 125 clk; a plain one about 100
	always_comb begin
		rise    = tx_nibble_clock_out & ~nc_q;
		long_p  = (per_q > 8'd110) && (per_q != 8'hFF);
		// the start-up period begins before any bit edge, so it is not measured
		per_d   = rise ? (seen_q ? 8'h00 : 8'hFF) : ((per_q == 8'hFF) ? per_q : per_q + 8'h01);
		sh_d    = rise ? (long_p ? 5'h00 : sh_q + 5'h01) : sh_q;
		// a stalled period of unknown length loses the run position until the next long one
		lsync_d = (lsync_q & ~(rise & (per_q == 8'hFF))) | (rise & long_p);
		seen_d  = seen_q | rise;
		cnt_d   = (frame_end_pulse & ~fe_q) ? 11'h000 : (rise ? cnt_q + 11'h001 : cnt_q);
		up_d    = (up_q == 3'h7) ? up_q : up_q + 3'h1;
	end

	// history registers only
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			nc_q    <= 1'b0;
			fe_q    <= 1'b0;
			lsync_q <= 1'b0;
			per_q   <= 8'hFF;
			sh_q    <= 5'h00;
			cnt_q   <= 11'h000;
			up_q    <= 3'h0;
			seen_q  <= 1'b0;
		end else begin
			nc_q    <= tx_nibble_clock_out;
			fe_q    <= frame_end_pulse;
			lsync_q <= lsync_d;
			per_q   <= per_d;
			sh_q    <= sh_d;
			cnt_q   <= cnt_d;
			up_q    <= up_d;
			seen_q  <= seen_d;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	a_oh_ind_low: assert property (overhead_indicator == 1'b0)
		else $error("overhead indicator driven high");
	a_nib_period: assert property (rise && per_q != 8'hFF |->
			per_q inside {[8'd97:8'd101], [8'd122:8'd126]})
		else $error("nibble clock period neither four nor five bit cycles");
	a_long_at_run: assert property (rise && lsync_q |-> long_p == (sh_q == 5'd20))
		else $error("stretched period not after twenty plain ones");
	a_frame_nibs: assert property (frame_end_pulse && !fe_q |-> cnt_q == 11'd1175)
		else $error("frame end not on the last of 1176 nibbles");
	a_fe_on_rise: assert property (frame_end_pulse != fe_q |-> rise)
		else $error("frame end moved off a nibble boundary");
	a_fe_one_nib: assert property (rise && fe_q |-> !frame_end_pulse)
		else $error("frame end held past one nibble period");
	a_rec_echo: assert property (up_q == 3'h7 |->
			recovered_clock_out == $past(line_clock, 3))
		else $error("recovered clock not echoed");
	a_sel_high: assert property (nibble_interface_select == 1'b1)
		else $error("nibble interface select dropped");
	a_data_on_rise: assert property ($changed(tx_payload_nibble) |->
			tx_nibble_clock_out && per_q < 8'd8)
		else $error("payload changed away from a nibble clock rise");
	a_ref_after_end: assert property ($rose(frame_start_reference) |->
			$past(frame_end_pulse, 8) && per_q < 8'd8)
		else $error("frame reference not on the first nibble after frame end");
	a_ref_one_nib: assert property ($fell(frame_start_reference) |->
			tx_nibble_clock_out && per_q < 8'd8)
		else $error("frame reference not one nibble period long");
endmodule
